/* File: fmfh_map.vh */
`ifndef FMFH_MAP_VH
`define FMFH_MAP_VH

// Register byte offsets
`define FMFH_REG_CTRL 8'h00
`define FMFH_REG_DELAY 8'h04
`define FMFH_REG_STATUS 8'h08
`define FMFH_REG_IRQ_STAT 8'h0c
`define FMFH_REG_IRQ_MASK 8'h10
`define FMFH_REG_CMD 8'h14
`define FMFH_REG_ALARM 8'h18

// Control register fields
`define FMFH_CTRL_POL_LSB 0
`define FMFH_CTRL_POL_MSB 1
`define FMFH_CTRL_ACT_HIGH 4
`define FMFH_CTRL_COAST_DI_ONLY 5
`define FMFH_CTRL_RESET 32'h0000_0010
`define FMFH_DELAY_RESET 32'h0000_0000

// Command register fields
`define FMFH_CMD_MAN_RESET 0
`define FMFH_CMD_CLR_WAS 1

// Fault policy values
`define FMFH_POL_TRIP_LOCK 2'h0
`define FMFH_POL_RESET_A 2'h1
`define FMFH_POL_RESET_B 2'h2
`define FMFH_POL_BYPASS 2'h3

// Interrupt status bits
`define FMFH_IRQ_TRIP 0
`define FMFH_IRQ_LOCK 1
`define FMFH_IRQ_BYPASS 2
`define FMFH_IRQ_FIRE_ON 3
`define FMFH_IRQ_WAS_ACTIVE 4
`define FMFH_IRQ_AUTO_RST 5
`define FMFH_IRQ_WIDTH 6

// Alarm numbers with special handling
`define FMFH_ALM_WAS_ACTIVE 7'h50

// Timing
`define FMFH_CLK_PERIOD_NS 8
`define FMFH_TICK_TIME_NS 1000000
`define FMFH_TICK_CYCLES ((`FMFH_TICK_TIME_NS + `FMFH_CLK_PERIOD_NS - 1) / `FMFH_CLK_PERIOD_NS)
`define FMFH_BLINK_TICKS 500
`define FMFH_AUTO_RST_TICKS 1

`endif

/* File: fmfh_sync.v */
module fmfh_sync #(
    parameter WIDTH = 2
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

/* File: fmfh_core.v */
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "fmfh_map.vh"
module fmfh_core #(
    parameter TICK_CYCLES = `FMFH_TICK_CYCLES,
    parameter BLINK_TICKS = `FMFH_BLINK_TICKS,
    parameter AUTO_RST_TICKS = `FMFH_AUTO_RST_TICKS
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire fire_pin_i,
    input wire coast_pin_i,
    input wire bus_coast_i,
    input wire alarm_valid_i,
    input wire [6:0] alarm_code_i,
    input wire limit_exceeded_i,
    output reg trip_o,
    output reg lock_o,
    output reg bypass_path_o,
    output reg bypass_out_o,
    output reg fire_active_o,
    output reg warn_flash_o,
    output reg irq_o
);
    localparam ST_RUN = 3'h0;
    localparam ST_TRIP = 3'h1;
    localparam ST_LOCK = 3'h2;
    localparam ST_BYP_WAIT = 3'h3;
    localparam ST_BYPASS = 3'h4;
    localparam CL_HARD = 2'h0;
    localparam CL_LOCKBYP = 2'h1;
    localparam CL_LOCK_ONLY = 2'h2;
    localparam CL_PLAIN = 2'h3;
    // Alarm classes: hard faults, lock-or-bypass, lock only, plain trip
    function [1:0] alarm_class;
        input [6:0] code;
        begin
            case (code)
                7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h25: alarm_class = CL_HARD;
                7'h04, 7'h1d: alarm_class = CL_LOCKBYP;
                7'h63: alarm_class = CL_LOCK_ONLY;
                default: alarm_class = CL_PLAIN;
            endcase
        end
    endfunction

    function is_reg;
        input [7:0] addr;
        input [7:0] offs;
        begin
            is_reg = (addr[7:2] == offs[7:2]);
        end
    endfunction

    wire [1:0] pins_sync;
    fmfh_sync #(
        .WIDTH(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_i({coast_pin_i, fire_pin_i}),
        .sync_o(pins_sync)
    );

    reg [31:0] ctrl_q;
    reg [31:0] delay_q;
    reg [`FMFH_IRQ_WIDTH-1:0] irq_stat_q;
    reg [`FMFH_IRQ_WIDTH-1:0] irq_mask_q;
    reg [6:0] last_alarm_q;
    reg was_active_q;
    reg [2:0] state_q;
    reg [31:0] tick_cnt_q;
    reg [31:0] wait_cnt_q;
    reg [31:0] blink_cnt_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg [2:0] state_d;
    reg [`FMFH_IRQ_WIDTH-1:0] irq_ev;

    wire [1:0] policy = ctrl_q[`FMFH_CTRL_POL_MSB:`FMFH_CTRL_POL_LSB];
    wire act_level = pins_sync[0] ~^ ctrl_q[`FMFH_CTRL_ACT_HIGH];
    wire bus_coast_eff = bus_coast_i & ~ctrl_q[`FMFH_CTRL_COAST_DI_ONLY];
    // Coast input low, or fieldbus coast while FMFH_CTRL_COAST_DI_ONLY is clear, blocks emergency run
    wire fire_now = act_level & (policy != `FMFH_POL_TRIP_LOCK) & pins_sync[1] & ~bus_coast_eff;
    wire tick = (tick_cnt_q == TICK_CYCLES - 1);

    // Internal alarm 80 is raised on the cycle emergency run ends
    wire ev80 = fire_active_o & ~fire_now;
    wire alm_any = alarm_valid_i | ev80;
    wire [6:0] alm_code = alarm_valid_i ? alarm_code_i : `FMFH_ALM_WAS_ACTIVE;
    wire [1:0] alm_cl = alarm_class(alm_code);
    wire pol_auto = (policy == `FMFH_POL_RESET_A) | (policy == `FMFH_POL_RESET_B);
    wire pol_byp = (policy == `FMFH_POL_BYPASS);
    wire wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire rd_fire = s_axi_arvalid & s_axi_arready;
    wire cmd_wr = wr_fire & is_reg(awaddr_q, `FMFH_REG_CMD) & wstrb_q[0];
    wire man_reset = cmd_wr & wdata_q[`FMFH_CMD_MAN_RESET];
    wire clr_was = cmd_wr & wdata_q[`FMFH_CMD_CLR_WAS];

    always @* begin
        state_d = state_q;
        irq_ev = {`FMFH_IRQ_WIDTH{1'b0}};
        case (state_q)
            ST_RUN: begin
                if (alm_any) begin
                    if (!fire_now) begin
                        // Normal handling for every alarm, emergency run or not configured
                        state_d = (alm_cl == CL_PLAIN) ? ST_TRIP : ST_LOCK;
                    end else if (pol_byp && (alm_cl == CL_HARD || alm_cl == CL_LOCKBYP)) begin
                        state_d = ST_BYP_WAIT;
                    end else if (pol_auto && alm_cl == CL_HARD) begin
                        state_d = ST_TRIP;
                    end
                    // Other alarms are ignored during emergency run; no lockout possible
                end
            end
            ST_TRIP: begin
                if (man_reset) begin
                    state_d = ST_RUN;
                end else if (fire_now && pol_auto && tick && wait_cnt_q >= AUTO_RST_TICKS - 1) begin
                    state_d = ST_RUN;
                    irq_ev[`FMFH_IRQ_AUTO_RST] = 1'b1;
                end
            end
            ST_LOCK: begin
                // Lockout is left only through the block reset
                state_d = ST_LOCK;
            end
            ST_BYP_WAIT: begin
                if (tick && wait_cnt_q >= delay_q) begin
                    state_d = ST_BYPASS;
                end
            end
            ST_BYPASS: begin
                state_d = ST_BYPASS;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        if (state_d == ST_TRIP && state_q != ST_TRIP) begin
            irq_ev[`FMFH_IRQ_TRIP] = 1'b1;
        end
        if (state_d == ST_LOCK && state_q != ST_LOCK) begin
            irq_ev[`FMFH_IRQ_LOCK] = 1'b1;
        end
        if (state_d == ST_BYPASS && state_q != ST_BYPASS) begin
            irq_ev[`FMFH_IRQ_BYPASS] = 1'b1;
        end
        if (fire_now && !fire_active_o) begin
            irq_ev[`FMFH_IRQ_FIRE_ON] = 1'b1;
        end
        if (ev80) begin
            irq_ev[`FMFH_IRQ_WAS_ACTIVE] = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RUN;
            tick_cnt_q <= 32'h0000_0000;
            wait_cnt_q <= 32'h0000_0000;
            blink_cnt_q <= 32'h0000_0000;
            last_alarm_q <= 7'h00;
            was_active_q <= 1'b0;
            trip_o <= 1'b0;
            lock_o <= 1'b0;
            bypass_path_o <= 1'b0;
            bypass_out_o <= 1'b0;
            fire_active_o <= 1'b0;
            warn_flash_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            state_q <= state_d;
            tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
            if (state_d != state_q) begin
                wait_cnt_q <= 32'h0000_0000;
            end else if (tick) begin
                wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
            end
            if (alm_any) begin
                last_alarm_q <= alm_code;
            end
            if (ev80) begin
                was_active_q <= 1'b1;
            end else if (clr_was) begin
                was_active_q <= 1'b0;
            end
            fire_active_o <= fire_now;
            trip_o <= (state_d == ST_TRIP) | (state_d == ST_LOCK);
            lock_o <= (state_d == ST_LOCK);
            bypass_path_o <= (state_d == ST_BYP_WAIT) | (state_d == ST_BYPASS);
            bypass_out_o <= (state_d == ST_BYPASS);
            // Blink only while the limit is exceeded under emergency run
            if (fire_now && limit_exceeded_i) begin
                if (tick) begin
                    if (blink_cnt_q >= BLINK_TICKS - 1) begin
                        blink_cnt_q <= 32'h0000_0000;
                        warn_flash_o <= ~warn_flash_o;
                    end else begin
                        blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
                    end
                end
            end else begin
                blink_cnt_q <= 32'h0000_0000;
                warn_flash_o <= 1'b0;
            end
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // AXI4-Lite slave: address and data are taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            ctrl_q <= `FMFH_CTRL_RESET;
            delay_q <= `FMFH_DELAY_RESET;
            irq_mask_q <= {`FMFH_IRQ_WIDTH{1'b0}};
            irq_stat_q <= {`FMFH_IRQ_WIDTH{1'b0}};
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (is_reg(awaddr_q, `FMFH_REG_CTRL) && wstrb_q[0]) begin
                    ctrl_q <= {26'h0, wdata_q[5:4], 2'h0, wdata_q[1:0]};
                end else if (is_reg(awaddr_q, `FMFH_REG_DELAY)) begin
                    delay_q <= {wstrb_q[3] ? wdata_q[31:24] : delay_q[31:24],
                        wstrb_q[2] ? wdata_q[23:16] : delay_q[23:16],
                        wstrb_q[1] ? wdata_q[15:8] : delay_q[15:8],
                        wstrb_q[0] ? wdata_q[7:0] : delay_q[7:0]};
                end else if (is_reg(awaddr_q, `FMFH_REG_IRQ_MASK) && wstrb_q[0]) begin
                    irq_mask_q <= wdata_q[`FMFH_IRQ_WIDTH-1:0];
                end else if (!is_reg(awaddr_q, `FMFH_REG_CMD) && !is_reg(awaddr_q, `FMFH_REG_STATUS)
                        && !is_reg(awaddr_q, `FMFH_REG_IRQ_STAT) && !is_reg(awaddr_q, `FMFH_REG_ALARM)) begin
                    s_axi_bresp <= 2'h2;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            // New events win over the clear-on-read
            if (rd_fire && is_reg(s_axi_araddr, `FMFH_REG_IRQ_STAT)) begin
                irq_stat_q <= irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                if (is_reg(s_axi_araddr, `FMFH_REG_CTRL)) begin
                    s_axi_rdata <= ctrl_q;
                end else if (is_reg(s_axi_araddr, `FMFH_REG_DELAY)) begin
                    s_axi_rdata <= delay_q;
                end else if (is_reg(s_axi_araddr, `FMFH_REG_STATUS)) begin
                    s_axi_rdata <= {21'h0, was_active_q, warn_flash_o, fire_active_o, bypass_out_o,
                        bypass_path_o, lock_o, trip_o, 1'b0, state_q};
                end else if (is_reg(s_axi_araddr, `FMFH_REG_IRQ_STAT)) begin
                    s_axi_rdata <= {26'h0, irq_stat_q};
                end else if (is_reg(s_axi_araddr, `FMFH_REG_IRQ_MASK)) begin
                    s_axi_rdata <= {26'h0, irq_mask_q};
                end else if (is_reg(s_axi_araddr, `FMFH_REG_ALARM)) begin
                    s_axi_rdata <= {25'h0, last_alarm_q};
                end else if (is_reg(s_axi_araddr, `FMFH_REG_CMD)) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

/* File: fmfh_plant.sv */
module fmfh_plant (
    input logic aclk,
    input logic want_fire,
    input logic act_high,
    input logic coast_req,
    input logic bus_coast_req,
    output logic fire_pin,
    output logic coast_pin,
    output logic bus_coast
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fire_pin = 1'b0;
        coast_pin = 1'b1;
        bus_coast = 1'b0;
    end
    // Wiring changes land on the clock, like relay contacts scanned by the building controller
    always @(posedge aclk) begin
        fire_pin <= want_fire ~^ act_high;
        coast_pin <= !coast_req;
        bus_coast <= bus_coast_req;
    end
endmodule

/* File: fmfh_props.sv */
module fmfh_props (
    input logic aclk,
    input logic aresetn,
    input logic alarm_valid_i,
    input logic [6:0] alarm_code_i,
    input logic trip_o,
    input logic lock_o,
    input logic bypass_path_o,
    input logic bypass_out_o,
    input logic fire_active_o,
    input logic warn_flash_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire run = !trip_o && !bypass_path_o;
    wire hard = alarm_code_i inside {13, 14, 15, 16, 37};
    a_lock_is_trip: assert property (lock_o |-> trip_o) else $error("lock without trip");
    a_no_fire_lock: assert property (fire_active_o |-> !$rose(lock_o)) else $error("lock in fire run");
    a_lock_holds: assert property (lock_o |=> lock_o) else $error("lock left without reset");
    a_bypass_stays: assert property (bypass_out_o |=> bypass_out_o && bypass_path_o) else $error("bypass dropped");
    a_plain_trip: assert property (alarm_valid_i && run |=> trip_o || fire_active_o)
        else $error("alarm without trip");
    a_hard_trips: assert property (alarm_valid_i && run && hard |=> trip_o || bypass_path_o)
        else $error("hard alarm ignored");
    a_phase_nolock: assert property (alarm_valid_i && run && alarm_code_i inside {[30:32]}
        |=> !lock_o && !bypass_path_o) else $error("phase alarm locked");
    a_mains_handling: assert property (alarm_valid_i && run && alarm_code_i inside {4, 29}
        |=> lock_o || bypass_path_o || (fire_active_o && !trip_o)) else $error("mains alarm misrouted");
    a_was_active_trip: assert property ($fell(fire_active_o) && $past(run) |-> trip_o)
        else $error("no trip after fire run");
    a_warn_idle: assert property (!fire_active_o [*3] |-> !warn_flash_o) else $error("warning outside fire");
endmodule
bind fmfh_core fmfh_props u_props (.aclk, .aresetn, .alarm_valid_i, .alarm_code_i, .trip_o, .lock_o,
    .bypass_path_o, .bypass_out_o, .fire_active_o, .warn_flash_o);

/* File: fmfh_tb.sv */
`include "fmfh_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic fire_pin_i, coast_pin_i, bus_coast_i, alarm_valid_i = 0, limit_exceeded_i = 0;
    logic [6:0] alarm_code_i = 0;
    logic trip_o, lock_o, bypass_path_o, bypass_out_o, fire_active_o, warn_flash_o, irq_o;
    logic want = 0, ahigh = 1, coast = 0, bcoast = 0;
    logic [6:0] tbl[8] = '{4, 13, 29, 30, 37, 99, 16, 2};
    logic [31:0] seed = 32'h0000b1e9;
    int error_cnt = 0, n_checks = 0;
    always #4 aclk = ~aclk;
    // Short ticks keep bypass delays and blink periods to under two dozen cycles
    fmfh_core #(.TICK_CYCLES(4), .BLINK_TICKS(2), .AUTO_RST_TICKS(1)) u_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fire_pin_i,
        .coast_pin_i, .bus_coast_i, .alarm_valid_i, .alarm_code_i, .limit_exceeded_i, .trip_o,
        .lock_o, .bypass_path_o, .bypass_out_o, .fire_active_o, .warn_flash_o, .irq_o);
    fmfh_plant u_plant (.aclk, .want_fire(want), .act_high(ahigh), .coast_req(coast),
        .bus_coast_req(bcoast), .fire_pin(fire_pin_i), .coast_pin(coast_pin_i), .bus_coast(bus_coast_i));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic exp_lock(input logic [6:0] c);
        return c inside {4, 13, 14, 15, 16, 29, 37, 99};
    endfunction
    // 0 ignored, 1 trip, 2 bypass
    function logic [1:0] exp_fire(input logic [1:0] p, input logic [6:0] c);
        if (p == `FMFH_POL_BYPASS && exp_lock(c) && c != 99) return 2'h2;
        if (c inside {13, 14, 15, 16, 37}) return 2'h1;
        return 2'h0;
    endfunction
    function logic pick(input int s);
        case (s)
            0: return fire_active_o;
            1: return trip_o;
            2: return bypass_out_o;
            default: return warn_flash_o;
        endcase
    endfunction
    task end_sim();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task tmo();
        error_cnt++;
        $display("ERROR %0t: wait timed out", $time);
        end_sim();
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task axi(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        if (n >= 40) tmo();
        r = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 0;
        s_axi_rready <= 0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 0);
        logic [31:0] r;
        logic [1:0] rs;
        axi(1, a, d, r, rs);
        chk(rs, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] es = 0);
        logic [31:0] r;
        logic [1:0] rs;
        axi(0, a, 0, r, rs);
        chk(r, e);
        chk(rs, es);
    endtask
    task wait_for(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v && n < 60) begin
            @(negedge aclk);
            n++;
        end
        if (pick(s) !== v) tmo();
    endtask
    task alm(input logic [6:0] c);
        @(posedge aclk);
        alarm_valid_i <= 1;
        alarm_code_i <= c;
        @(posedge aclk);
        alarm_valid_i <= 0;
        @(negedge aclk);
    endtask
    task rst();
        @(posedge aclk);
        aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
    endtask
    task pins(input logic w, input logic a, input logic c, input logic b);
        @(posedge aclk);
        want <= w;
        ahigh <= a;
        coast <= c;
        bcoast <= b;
    endtask
    initial begin
        int c, n, p, d;
        rst();
        rd(`FMFH_REG_CTRL, `FMFH_CTRL_RESET);
        rd(`FMFH_REG_DELAY, `FMFH_DELAY_RESET);
        rd(8'h1c, 0, 2);
        wr(8'h1c, 1, 2);
        for (int i = 0; i < 10; i++) begin
            c = (i < 6) ? tbl[i] : xs() % 100;
            rst();
            if (i == 0) wr(`FMFH_REG_IRQ_MASK, 32'h3f);
            else wr(`FMFH_REG_CTRL, 32'h10 | (i % 4));
            alm(c[6:0]);
            chk(trip_o, 1);
            chk(lock_o, exp_lock(c[6:0]));
            @(negedge aclk);
            chk(irq_o, i == 0);
            if (i == 0) begin
                rd(`FMFH_REG_IRQ_STAT, 32'h2);
                repeat (3) @(negedge aclk);
                chk(irq_o, 0);
            end
            if (!exp_lock(c[6:0])) begin
                wr(`FMFH_REG_CMD, 1);
                @(negedge aclk);
                chk(trip_o, 0);
            end
        end
        rst();
        pins(1, 1, 0, 0);
        repeat (8) @(negedge aclk);
        chk(fire_active_o, 0);
        for (int i = 0; i < 12; i++) begin
            p = 1 + xs() % 3;
            d = 1 + xs() % 4;
            c = tbl[xs() % 8];
            rst();
            wr(`FMFH_REG_DELAY, d);
            wr(`FMFH_REG_CTRL, 32'h10 | p);
            wait_for(0, 1, n);
            @(posedge aclk);
            limit_exceeded_i <= 1;
            wait_for(3, 1, n);
            @(posedge aclk);
            limit_exceeded_i <= 0;
            alm(c[6:0]);
            chk({bypass_path_o, trip_o}, exp_fire(p[1:0], c[6:0]));
            chk(lock_o, 0);
            if (exp_fire(p[1:0], c[6:0]) == 1) wait_for(1, 0, n);
            if (exp_fire(p[1:0], c[6:0]) == 2) begin
                wait_for(2, 1, n);
                chk(n >= (d - 1) * 4 && n <= (d + 1) * 4 + 2, 1);
            end
        end
        rst();
        wr(`FMFH_REG_CTRL, 32'h11);
        wait_for(0, 1, n);
        pins(1, 1, 0, 1);
        wait_for(0, 0, n);
        chk(trip_o, 1);
        rd(`FMFH_REG_STATUS, 32'h0000_0411);
        rd(`FMFH_REG_ALARM, 32'h0000_0050);
        rd(`FMFH_REG_IRQ_STAT, 32'h0000_0019);
        wr(`FMFH_REG_CMD, 32'h0000_0003);
        rd(`FMFH_REG_STATUS, 32'h0000_0000);
        wr(`FMFH_REG_CTRL, 32'h31);
        wait_for(0, 1, n);
        pins(1, 1, 1, 1);
        wait_for(0, 0, n);
        pins(0, 0, 0, 0);
        wr(`FMFH_REG_CTRL, 32'h01);
        repeat (6) @(negedge aclk);
        chk(fire_active_o, 0);
        pins(1, 0, 0, 0);
        wait_for(0, 1, n);
        end_sim();
    end
endmodule
